// [verilog/pafm_pkg.sv]
// package for the port alternate-function multiplexer: offsets, fields, encodings
// What this block does
// - larger packages take external clock on port B pin 3 when enabled and select is 0
// - smallest package takes the external clock on port A pin 1 instead
// - port A has no set-select registers on larger packages
// - port A enable bit alone connects that pin's single function, except pin 1 on the smallest package
// - port A pins 0 and 6 carry timer input or complement output per timer mode
// - port A map: timer0, uart0 enable/cts/rx/tx, timer1 per pin
// - ports B and C ignore second select; one first-select bit picks between two
// - ports B and C selection takes effect only with the enable bit set
// - port B select-1 map: analog inputs, lpo pins, adc reference; pins 6,7 reserved
// - adc reference on port B pin 5 exists only on the 28-pin package
// - port C select-1 is led drive plus analog; pin 3 select-0 is comparator output
// - adc reference on port C pin 2 exists only on the 20-pin package
// - alternate-function pins take direction from the peripheral, not the port
package pafm_pkg;
  // register word indices (address bits 5:2), one 32-bit word each
  localparam logic [3:0] PAFM_A_PA_OUT   = 4'h0;
  localparam logic [3:0] PAFM_A_PA_DIR   = 4'h1;
  localparam logic [3:0] PAFM_A_PA_AF    = 4'h2;
  localparam logic [3:0] PAFM_A_PB_OUT   = 4'h3;
  localparam logic [3:0] PAFM_A_PB_DIR   = 4'h4;
  localparam logic [3:0] PAFM_A_PB_AF    = 4'h5;
  localparam logic [3:0] PAFM_A_PB_SEL1  = 4'h6;
  localparam logic [3:0] PAFM_A_PB_SEL2  = 4'h7;
  localparam logic [3:0] PAFM_A_PC_OUT   = 4'h8;
  localparam logic [3:0] PAFM_A_PC_DIR   = 4'h9;
  localparam logic [3:0] PAFM_A_PC_AF    = 4'ha;
  localparam logic [3:0] PAFM_A_PC_SEL1  = 4'hb;
  localparam logic [3:0] PAFM_A_PC_SEL2  = 4'hc;
  localparam logic [3:0] PAFM_A_PIN_IN_A = 4'hd;
  localparam logic [3:0] PAFM_A_PIN_IN_B = 4'he;
  localparam logic [3:0] PAFM_A_PIN_IN_C = 4'hf;
  // reset values: all pins gpio input, low, nothing selected
  localparam logic [7:0] PAFM_RST_OUT = 8'h00;
  localparam logic [7:0] PAFM_RST_DIR = 8'h00;
  localparam logic [7:0] PAFM_RST_AF  = 8'h00;
  localparam logic [7:0] PAFM_RST_SEL = 8'h00;
  // dir register: bit 1 means output
  localparam int PAFM_PKG_8  = 8;
  localparam int PAFM_PKG_20 = 20;
  localparam int PAFM_PKG_28 = 28;
  // pin indices that carry special functions
  localparam int PAFM_BIT_TMR0_IO  = 0;
  localparam int PAFM_BIT_TMR0_OUT = 1;
  localparam int PAFM_BIT_UDE      = 2;
  localparam int PAFM_BIT_UCTS     = 3;
  localparam int PAFM_BIT_URX      = 4;
  localparam int PAFM_BIT_UTX      = 5;
  localparam int PAFM_BIT_TMR1_IO  = 6;
  localparam int PAFM_BIT_TMR1_OUT = 7;
  localparam int PAFM_BIT_EXTERNAL_CLOCK_INPUT_A  = 1;
  localparam int PAFM_BIT_EXTERNAL_CLOCK_INPUT_B  = 3;
  localparam int PAFM_BIT_VREF_B   = 5;
  localparam int PAFM_BIT_VREF_C   = 2;
  localparam int PAFM_BIT_COMPARATOR_OUTPUT_C   = 3;
  // port B select-1 functions exist on pins 0..5 only
  localparam logic [7:0] PAFM_PB_SEL1_VALID = 8'h3f;
  // port B select-0 only pin 3 has a function
  localparam logic [7:0] PAFM_PB_SEL0_VALID = 8'h08;
  localparam logic [7:0] PAFM_PC_SEL0_VALID = 8'h08;
  // analog mode for a pin: connected to the analog bus, digital buffer off
  typedef enum logic [1:0] {
    PAFM_MODE_GPIO,
    PAFM_MODE_DIGITAL,
    PAFM_MODE_ANALOG,
    PAFM_MODE_LED
  } pafm_mode_t;
  // avalon slave states
  typedef enum logic [1:0] {
    PAFM_BUS_IDLE,
    PAFM_BUS_ACK
  } pafm_bus_t;
endpackage : pafm_pkg

// [verilog/pafm_sync.sv]
// two-flop synchroniser for a bus of asynchronous pin inputs
`timescale 1ns/1ns
module pafm_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("pafm_sync: WIDTH must be at least 1");
    end
  end

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : pafm_sync

// [verilog/pafm_mux.sv]
// port alternate-function multiplexer with avalon-mm register slave
`timescale 1ns/1ns
module pafm_mux
  import pafm_pkg::*;
#(
  parameter int PKG_PINS = 28
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [1:0]  avs_response,
  // pins, three signals each
  input  wire logic [7:0]  pa_in,
  output logic      [7:0]  pa_out,
  output logic      [7:0]  pa_oe,
  input  wire logic [7:0]  pb_in,
  output logic      [7:0]  pb_out,
  output logic      [7:0]  pb_oe,
  input  wire logic [7:0]  pc_in,
  output logic      [7:0]  pc_out,
  output logic      [7:0]  pc_oe,
  // analog switch and led enables per pin
  output logic      [7:0]  pa_analog_en,
  output logic      [7:0]  pb_analog_en,
  output logic      [7:0]  pc_analog_en,
  output logic      [7:0]  pc_led_en,
  output logic             adc_vref_en,
  // timer 0 and timer 1
  input  wire logic        timer0_output,
  input  wire logic        timer0_output_n,
  input  wire logic        timer0_out_mode,
  output logic             timer0_input,
  input  wire logic        timer1_output,
  input  wire logic        timer1_output_n,
  input  wire logic        timer1_out_mode,
  output logic             timer1_input,
  // uart 0 with infrared
  input  wire logic        uart0_driver_enable,
  output logic             uart0_clear_to_send,
  output logic             uart0_receive,
  input  wire logic        uart0_transmit,
  // comparator and clock input
  input  wire logic        comparator_output,
  output logic             external_clock_input,
  output logic             external_clock_valid
);
  logic        rst_meta_reg;
  logic        rst_n;
  logic [7:0]  pa_out_reg;
  logic [7:0]  pa_dir_reg;
  logic [7:0]  pa_af_reg;
  logic [7:0]  pb_out_reg;
  logic [7:0]  pb_dir_reg;
  logic [7:0]  pb_af_reg;
  logic [7:0]  pb_sel1_reg;
  logic [7:0]  pb_sel2_reg;
  logic [7:0]  pc_out_reg;
  logic [7:0]  pc_dir_reg;
  logic [7:0]  pc_af_reg;
  logic [7:0]  pc_sel1_reg;
  logic [7:0]  pc_sel2_reg;
  logic [7:0]  pa_sync;
  logic [7:0]  pb_sync;
  logic [7:0]  pc_sync;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0]  resp_reg;
  pafm_bus_t   bus_reg;
  pafm_bus_t   bus_next;

  initial
  begin
    if (PKG_PINS != PAFM_PKG_8 && PKG_PINS != PAFM_PKG_20 && PKG_PINS != PAFM_PKG_28)
    begin
      $error("pafm_mux: PKG_PINS must be 8, 20 or 28");
    end
  end

  // reset release through two flops
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  pafm_sync #(.WIDTH(24)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({pc_in, pb_in, pa_in}),
    .q     ({pc_sync, pb_sync, pa_sync})
  );

  // package variants: smallest package has port A [5:0] only
  localparam bit IS_SMALL = (PKG_PINS == PAFM_PKG_8);
  localparam bit IS_20    = (PKG_PINS == PAFM_PKG_20);
  localparam bit IS_28    = (PKG_PINS == PAFM_PKG_28);
  localparam logic [7:0] PA_EXIST = IS_SMALL ? 8'h3f : 8'hff;
  localparam logic [7:0] PB_EXIST = IS_SMALL ? 8'h00 : (IS_20 ? 8'h0f : 8'hff);
  localparam logic [7:0] PC_EXIST = IS_SMALL ? 8'h00 : (IS_20 ? 8'h0f : 8'hff);
  // small package has no port B, but keeps the pin 1 clock select in these registers
  localparam logic [7:0] PB_SEL_MASK = IS_SMALL ? 8'h02 : PB_EXIST;

  // avalon decode: one word per register, byte lane 0 carries data
  wire [3:0] reg_idx   = avs_address[5:2];
  wire       addr_ok   = (avs_address[1:0] == 2'b00);
  wire       req       = (avs_read || avs_write) && bus_reg == PAFM_BUS_IDLE;
  // a write lands only at the edge that completes it, with waitrequest low
  wire       wr_go     = avs_write && bus_reg == PAFM_BUS_ACK && addr_ok && avs_byteenable[0];
  wire [7:0] wb        = avs_writedata[7:0];

  // register writes; port A select registers do not exist on larger packages
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pa_out_reg  <= PAFM_RST_OUT;
      pa_dir_reg  <= PAFM_RST_DIR;
      pa_af_reg   <= PAFM_RST_AF;
      pb_out_reg  <= PAFM_RST_OUT;
      pb_dir_reg  <= PAFM_RST_DIR;
      pb_af_reg   <= PAFM_RST_AF;
      pb_sel1_reg <= PAFM_RST_SEL;
      pb_sel2_reg <= PAFM_RST_SEL;
      pc_out_reg  <= PAFM_RST_OUT;
      pc_dir_reg  <= PAFM_RST_DIR;
      pc_af_reg   <= PAFM_RST_AF;
      pc_sel1_reg <= PAFM_RST_SEL;
      pc_sel2_reg <= PAFM_RST_SEL;
    end
    else if (wr_go)
    begin
      unique case (reg_idx)
        PAFM_A_PA_OUT:  pa_out_reg  <= wb & PA_EXIST;
        PAFM_A_PA_DIR:  pa_dir_reg  <= wb & PA_EXIST;
        PAFM_A_PA_AF:   pa_af_reg   <= wb & PA_EXIST;
        PAFM_A_PB_OUT:  pb_out_reg  <= wb & PB_EXIST;
        PAFM_A_PB_DIR:  pb_dir_reg  <= wb & PB_EXIST;
        PAFM_A_PB_AF:   pb_af_reg   <= wb & PB_EXIST;
        PAFM_A_PB_SEL1: pb_sel1_reg <= wb & PB_SEL_MASK;
        PAFM_A_PB_SEL2: pb_sel2_reg <= wb & PB_SEL_MASK;
        PAFM_A_PC_OUT:  pc_out_reg  <= wb & PC_EXIST;
        PAFM_A_PC_DIR:  pc_dir_reg  <= wb & PC_EXIST;
        PAFM_A_PC_AF:   pc_af_reg   <= wb & PC_EXIST;
        PAFM_A_PC_SEL1: pc_sel1_reg <= wb & PC_EXIST;
        PAFM_A_PC_SEL2: pc_sel2_reg <= wb & PC_EXIST;
        default:        ;
      endcase
    end
  end

  // read mux; second select is stored for software and steers only the small-package pin 1 clock
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    unique case (reg_idx)
      PAFM_A_PA_OUT:   rdata_next[7:0] = pa_out_reg;
      PAFM_A_PA_DIR:   rdata_next[7:0] = pa_dir_reg;
      PAFM_A_PA_AF:    rdata_next[7:0] = pa_af_reg;
      PAFM_A_PB_OUT:   rdata_next[7:0] = pb_out_reg;
      PAFM_A_PB_DIR:   rdata_next[7:0] = pb_dir_reg;
      PAFM_A_PB_AF:    rdata_next[7:0] = pb_af_reg;
      PAFM_A_PB_SEL1:  rdata_next[7:0] = pb_sel1_reg;
      PAFM_A_PB_SEL2:  rdata_next[7:0] = pb_sel2_reg;
      PAFM_A_PC_OUT:   rdata_next[7:0] = pc_out_reg;
      PAFM_A_PC_DIR:   rdata_next[7:0] = pc_dir_reg;
      PAFM_A_PC_AF:    rdata_next[7:0] = pc_af_reg;
      PAFM_A_PC_SEL1:  rdata_next[7:0] = pc_sel1_reg;
      PAFM_A_PC_SEL2:  rdata_next[7:0] = pc_sel2_reg;
      PAFM_A_PIN_IN_A: rdata_next[7:0] = pa_sync & PA_EXIST;
      PAFM_A_PIN_IN_B: rdata_next[7:0] = pb_sync & PB_EXIST;
      PAFM_A_PIN_IN_C: rdata_next[7:0] = pc_sync & PC_EXIST;
      default:         rdata_next = 32'h0000_0000;
    endcase
    if (!addr_ok)
    begin
      rdata_next = 32'h0000_0000;
    end
  end

  // one wait cycle, then an acknowledge cycle with waitrequest low
  assign bus_next = req ? PAFM_BUS_ACK : PAFM_BUS_IDLE;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_reg   <= PAFM_BUS_IDLE;
      rdata_reg <= 32'h0000_0000;
      resp_reg  <= 2'b00;
    end
    else
    begin
      bus_reg   <= bus_next;
      rdata_reg <= (req && avs_read) ? rdata_next : rdata_reg;
      resp_reg  <= req ? (addr_ok ? 2'b00 : 2'b10) : resp_reg;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && bus_reg != PAFM_BUS_ACK;
  assign avs_readdata    = rdata_reg;
  assign avs_response    = resp_reg;

  // function selects per pin
  wire [7:0] pa_alt     = pa_af_reg & PA_EXIST;
  // small package keeps selection for port A pin 1 in port B select regs
  wire       small_clk  = IS_SMALL && pa_af_reg[PAFM_BIT_EXTERNAL_CLOCK_INPUT_A]
                          && pb_sel1_reg[PAFM_BIT_EXTERNAL_CLOCK_INPUT_A]
                          && !pb_sel2_reg[PAFM_BIT_EXTERNAL_CLOCK_INPUT_A];
  wire [7:0] pb_sel1on  = pb_af_reg & pb_sel1_reg & PAFM_PB_SEL1_VALID;
  wire [7:0] pb_sel0on  = pb_af_reg & ~pb_sel1_reg & PAFM_PB_SEL0_VALID;
  wire [7:0] pc_ledon   = pc_af_reg & pc_sel1_reg;
  wire [7:0] pc_sel0on  = pc_af_reg & ~pc_sel1_reg & PAFM_PC_SEL0_VALID;
  wire       big_clk    = !IS_SMALL && pb_sel0on[PAFM_BIT_EXTERNAL_CLOCK_INPUT_B];

  // port A digital drive; pins 0 and 6 follow their timer's mode
  wire [7:0] pa_alt_oe;
  wire [7:0] pa_alt_do;
  // driver enable pin always driven while selected; as gpio it follows the dir register like any pin
  assign pa_alt_oe = {1'b1, timer1_out_mode, 1'b1, 1'b0,
                      1'b0, 1'b1, 1'b1, timer0_out_mode};
  assign pa_alt_do = {timer1_output, timer1_output_n, uart0_transmit, 1'b0,
                      1'b0, uart0_driver_enable, timer0_output, timer0_output_n};

  // direction handed to the peripheral in alternate mode
  wire [7:0] pa_oe_mux  = (pa_alt & pa_alt_oe) | (~pa_alt & pa_dir_reg);
  wire [7:0] pa_do_mux  = (pa_alt & pa_alt_do) | (~pa_alt & pa_out_reg);
  wire       pa1_clk    = IS_SMALL ? small_clk : 1'b0;
  wire [7:0] pa_oe_fin  = pa1_clk ? (pa_oe_mux & ~8'h02) : pa_oe_mux;

  // port B alternate functions are all inputs or analog
  wire [7:0] pb_alt     = pb_sel1on | pb_sel0on;
  wire [7:0] pc_cmp     = pc_sel0on;
  wire [7:0] pc_alt     = pc_ledon | pc_cmp;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pa_out <= 8'h00;
      pa_oe  <= 8'h00;
      pb_out <= 8'h00;
      pb_oe  <= 8'h00;
      pc_out <= 8'h00;
      pc_oe  <= 8'h00;
    end
    else
    begin
      pa_out <= pa_do_mux & PA_EXIST;
      pa_oe  <= pa_oe_fin & PA_EXIST;
      pb_out <= pb_out_reg & ~pb_alt;
      pb_oe  <= pb_dir_reg & ~pb_alt;
      // led drive sinks current: drive low while enabled, comparator drives pin 3
      pc_out <= (pc_out_reg & ~pc_alt) | (pc_cmp & {8{comparator_output}});
      pc_oe  <= (pc_dir_reg & ~pc_alt) | pc_cmp | pc_ledon;
    end
  end

  // analog and led enables, registered
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pa_analog_en <= 8'h00;
      pb_analog_en <= 8'h00;
      pc_analog_en <= 8'h00;
      pc_led_en    <= 8'h00;
      adc_vref_en  <= 1'b0;
    end
    else
    begin
      pa_analog_en <= 8'h00;
      pb_analog_en <= IS_28 ? pb_sel1on
                    : (pb_sel1on & ~(8'h01 << PAFM_BIT_VREF_B));
      pc_analog_en <= pc_ledon & 8'h07;
      pc_led_en    <= pc_ledon;
      adc_vref_en  <= (IS_28 && pb_sel1on[PAFM_BIT_VREF_B])
                    || (IS_20 && pc_ledon[PAFM_BIT_VREF_C]);
    end
  end

  // peripheral inputs; unselected uart inputs idle high as an undriven line would, timer and clock inputs low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer0_input         <= 1'b0;
      timer1_input         <= 1'b0;
      uart0_clear_to_send  <= 1'b1;
      uart0_receive        <= 1'b1;
      external_clock_input <= 1'b0;
      external_clock_valid <= 1'b0;
    end
    else
    begin
      timer0_input         <= pa_alt[PAFM_BIT_TMR0_IO] & pa_sync[PAFM_BIT_TMR0_IO];
      timer1_input         <= pa_alt[PAFM_BIT_TMR1_IO] & pa_sync[PAFM_BIT_TMR1_IO];
      uart0_clear_to_send  <= pa_alt[PAFM_BIT_UCTS] ? pa_sync[PAFM_BIT_UCTS] : 1'b1;
      uart0_receive        <= pa_alt[PAFM_BIT_URX] ? pa_sync[PAFM_BIT_URX] : 1'b1;
      external_clock_input <= big_clk ? pb_sync[PAFM_BIT_EXTERNAL_CLOCK_INPUT_B]
                            : (pa1_clk & pa_sync[PAFM_BIT_EXTERNAL_CLOCK_INPUT_A]);
      external_clock_valid <= big_clk || pa1_clk;
    end
  end
endmodule : pafm_mux

// [testbench/pafm_mux_props.sv]
// assertion checker for the port alternate-function multiplexer
`timescale 1ns/1ns
module pafm_mux_props #(
  parameter int PKG_PINS = 28
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // register bus
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response,
  // pins
  input wire logic [7:0]  pa_analog_en,
  input wire logic [7:0]  pb_oe,
  input wire logic [7:0]  pb_analog_en,
  input wire logic [7:0]  pc_analog_en,
  input wire logic [7:0]  pc_out,
  input wire logic [7:0]  pc_oe,
  input wire logic [7:0]  pc_led_en,
  input wire logic        adc_vref_en,
  input wire logic        external_clock_valid
);
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!arst_n);

  wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in the next cycle");
  resp_stand_a: assert property (!((avs_read || avs_write) && avs_waitrequest)
    |=> $stable(avs_response) && $stable(avs_readdata)) else $error("bus answer changed unasked");
  bad_addr_a: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'b00
    |-> avs_response == 2'b10 && avs_readdata == 32'h0) else $error("misaligned read answered");
  good_resp_a: assert property ((avs_read || avs_write) && !avs_waitrequest
    && avs_address[1:0] == 2'b00 |-> avs_response == 2'b00) else $error("aligned access refused");
  upper_zero_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  pa_digital_a: assert property (pa_analog_en == 8'h00)
    else $error("port a pin switched to analog");
  pb_reserved_a: assert property (pb_analog_en[7:6] == 2'b00)
    else $error("reserved port b pin went analog");
  analog_float_a: assert property ((pb_analog_en & pb_oe) == 8'h00)
    else $error("analog port b pin is driven");
  led_sink_a: assert property ((pc_led_en & ~pc_oe) == 8'h00 && (pc_led_en & pc_out) == 8'h00)
    else $error("led pin not sinking");
  vref_pkg_a: assert property (adc_vref_en
    |-> ((PKG_PINS == 20) ? pc_analog_en[2] : pb_analog_en[5]))
    else $error("reference enabled on wrong pin");
  clk_undriven_a: assert property (external_clock_valid && PKG_PINS != 8 |-> !pb_oe[3])
    else $error("clock input pin is driven");

  cover property (avs_write && !avs_waitrequest);
  cover property (external_clock_valid);
  cover property (pc_led_en == 8'hff);
endmodule : pafm_mux_props

bind pafm_mux pafm_mux_props #(.PKG_PINS(PKG_PINS)) u_pafm_mux_props (
  .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .pa_analog_en(pa_analog_en), .pb_oe(pb_oe),
  .pb_analog_en(pb_analog_en), .pc_analog_en(pc_analog_en), .pc_out(pc_out),
  .pc_oe(pc_oe), .pc_led_en(pc_led_en),
  .adc_vref_en(adc_vref_en), .external_clock_valid(external_clock_valid));

// [testbench/pafm_mux_tb_top.sv]
// self-checking bench for the port alternate-function multiplexer
`timescale 1ns/1ns
module pafm_mux_tb_top;
  import pafm_pkg::*;
  typedef struct packed { logic [3:0] word; logic [7:0] data; } pafm_row_t;
  logic        clk, arst_n, avs_read, avs_write, avs_waitrequest, adc_vref_en;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, r;
  logic [3:0]  avs_byteenable;
  logic [1:0]  avs_response, resp;
  logic [7:0]  pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, pc_in, pc_out, pc_oe;
  logic [7:0]  pa_analog_en, pb_analog_en, pc_analog_en, pc_led_en;
  logic        timer0_output, timer0_output_n, timer0_out_mode, timer0_input;
  logic        timer1_output, timer1_output_n, timer1_out_mode, timer1_input;
  logic        uart0_driver_enable, uart0_clear_to_send, uart0_receive, uart0_transmit;
  logic        comparator_output, external_clock_input, external_clock_valid;
  int          fails = 0;
  int          comparisons = 0;
  pafm_row_t   rows [13] = '{'{4'h0, 8'h5a}, '{4'h1, 8'ha5}, '{4'h2, 8'h3c}, '{4'h3, 8'h2a},
                             '{4'h4, 8'h15}, '{4'h5, 8'h21}, '{4'h6, 8'h0c}, '{4'h7, 8'h33},
                             '{4'h8, 8'ha5}, '{4'h9, 8'h3c}, '{4'ha, 8'hc3}, '{4'hb, 8'h99},
                             '{4'hc, 8'h66}};

  pafm_mux #(.PKG_PINS(28)) u_pafm_mux (
    .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
    .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .pc_in(pc_in), .pc_out(pc_out),
    .pc_oe(pc_oe), .pa_analog_en(pa_analog_en), .pb_analog_en(pb_analog_en),
    .pc_analog_en(pc_analog_en), .pc_led_en(pc_led_en), .adc_vref_en(adc_vref_en),
    .timer0_output(timer0_output), .timer0_output_n(timer0_output_n),
    .timer0_out_mode(timer0_out_mode), .timer0_input(timer0_input),
    .timer1_output(timer1_output), .timer1_output_n(timer1_output_n),
    .timer1_out_mode(timer1_out_mode), .timer1_input(timer1_input),
    .uart0_driver_enable(uart0_driver_enable), .uart0_clear_to_send(uart0_clear_to_send),
    .uart0_receive(uart0_receive), .uart0_transmit(uart0_transmit),
    .comparator_output(comparator_output), .external_clock_input(external_clock_input),
    .external_clock_valid(external_clock_valid));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic wrap_up();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  // a hang anywhere ends the run well after the tests should be over
  initial
  begin
    #200000;
    fails++;
    wrap_up();
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic [5:0] addr, input logic wr, input logic [7:0] wd,
                     input logic [3:0] be, output logic [31:0] rdata);
    int n;
    n = 0;
    @(posedge clk);
    avs_address    <= addr;
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_writedata  <= {24'h0, wd};
    avs_byteenable <= be;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    rdata = avs_readdata;
    resp  = avs_response;
    if (n >= 20)
    begin
      fails++;
      $display("wrong value waitrequest expected 0 seen 1");
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] w, input logic [7:0] d);
    logic [31:0] x;
    bus({w, 2'b00}, 1'b1, d, 4'hf, x);
  endtask : wr

  task automatic rchk(input logic [3:0] w, input logic [7:0] e, input string nm);
    logic [31:0] x;
    bus({w, 2'b00}, 1'b0, 8'h00, 4'hf, x);
    chk(nm, {24'h0, e}, x);
  endtask : rchk

  // pins pass two sync flops and an output register
  task automatic settle();
    repeat (5) @(posedge clk);
  endtask : settle

  task automatic do_reset();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset

  initial
  begin
    arst_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
    {pa_in, pb_in, pc_in, comparator_output, timer0_output, timer0_output_n} = '0;
    {timer0_out_mode, timer1_output, timer1_output_n, timer1_out_mode} = '0;
    {uart0_driver_enable, uart0_transmit} = '0;
    do_reset();
    for (int i = 0; i < 13; i++)
      rchk(i[3:0], PAFM_RST_SEL, "reset value");
    chk("reset pins", 11'h600, {uart0_clear_to_send, uart0_receive, pa_oe, external_clock_valid});
    foreach (rows[i])
      rchk_after_write(rows[i].word, rows[i].data);
    $display("test registers done");
    wr(PAFM_A_PA_DIR, 8'h00);
    @(posedge clk);
    pa_in <= 8'h41;
    {timer0_output, timer1_output, uart0_driver_enable, uart0_transmit} <= 4'hf;
    wr(PAFM_A_PA_AF, 8'hff);
    settle();
    chk("pa_oe", 8'ha6, pa_oe);
    chk("pa_out", 8'ha6, pa_out & 8'ha6);
    chk("port a inputs", 4'b1100, {timer0_input, timer1_input, uart0_clear_to_send, uart0_receive});
    @(posedge clk);
    {timer0_output, timer1_output, uart0_driver_enable, uart0_transmit} <= 4'h0;
    {timer0_out_mode, timer1_out_mode, timer0_output_n, timer1_output_n} <= 4'hf;
    settle();
    chk("pa_oe", 8'he7, pa_oe);
    chk("pa_out", 8'h41, pa_out & 8'he7);
    wr(PAFM_A_PA_OUT, 8'h05);
    wr(PAFM_A_PA_DIR, 8'h0f);
    wr(PAFM_A_PA_AF, 8'h00);
    settle();
    chk("pa gpio", 16'h0f05, {pa_oe, pa_out & 8'h0f});
    chk("port a idle", 4'b0011, {timer0_input, timer1_input, uart0_clear_to_send, uart0_receive});
    $display("test port_a done");
    wr(PAFM_A_PC_AF, 8'h00);
    wr(PAFM_A_PB_AF, 8'h00);
    wr(PAFM_A_PB_SEL1, 8'h00);
    wr(PAFM_A_PB_SEL2, 8'h3f);
    wr(PAFM_A_PB_DIR, 8'h3f);
    @(posedge clk);
    pb_in <= 8'h08;
    wr(PAFM_A_PB_AF, 8'h08);
    settle();
    chk("clock in", 2'b11, {external_clock_valid, external_clock_input});
    chk("pb_oe", 8'h37, pb_oe & 8'h3f);
    @(posedge clk);
    pb_in <= 8'h00;
    settle();
    chk("clock in", 1'b0, external_clock_input);
    wr(PAFM_A_PB_SEL1, 8'h08);
    settle();
    chk("pb analog", 9'h008, {external_clock_valid, pb_analog_en});
    wr(PAFM_A_PB_AF, 8'h00);
    wr(PAFM_A_PB_SEL1, 8'h3f);
    settle();
    chk("pb disabled", 16'h003f, {pb_analog_en, pb_oe & 8'h3f});
    chk("pb_out", 8'h2a, pb_out);
    wr(PAFM_A_PB_AF, 8'h3f);
    settle();
    chk("pb analog", 17'h13f00, {adc_vref_en, pb_analog_en, pb_oe});
    chk("pb_out", 8'h00, pb_out);
    $display("test port_b done");
    wr(PAFM_A_PB_AF, 8'h00);
    wr(PAFM_A_PC_SEL1, 8'hff);
    wr(PAFM_A_PC_AF, 8'hff);
    settle();
    chk("led", 17'h0ff07, {adc_vref_en, pc_led_en, pc_analog_en});
    @(posedge clk);
    comparator_output <= 1'b1;
    pc_in <= 8'h81;
    wr(PAFM_A_PC_SEL1, 8'h00);
    settle();
    chk("pc select 0", 18'h00003, {pc_led_en, pc_analog_en, pc_oe[3], pc_out[3]});
    $display("test port_c done");
    bus(6'h01, 1'b1, 8'hff, 4'hf, r);
    bus({PAFM_A_PA_OUT, 2'b00}, 1'b1, 8'hff, 4'he, r);
    rchk(PAFM_A_PA_OUT, 8'h05, "ignored write");
    bus(6'h05, 1'b0, 8'h00, 4'hf, r);
    chk("misaligned", 34'h200000000, {resp, r});
    wr(PAFM_A_PIN_IN_C, 8'h00);
    rchk(PAFM_A_PIN_IN_C, 8'h81, "pin input");
    chk("response", 2'b00, resp);
    $display("test bus done");
    wr(PAFM_A_PC_SEL1, 8'hff);
    settle();
    do_reset();
    rchk(PAFM_A_PC_AF, PAFM_RST_AF, "second reset");
    chk("second reset led", 8'h00, pc_led_en);
    $display("test reset done");
    wrap_up();
  end

  task automatic rchk_after_write(input logic [3:0] w, input logic [7:0] d);
    wr(w, d);
    rchk(w, d, "readback");
  endtask : rchk_after_write
endmodule : pafm_mux_tb_top
